// File: hw/scm_monitor.sv
// Purpose: sync check close permit and reverse sequence warning top
// Assumes: front-end quantities share mclk and are valid with sample_valid
// Notes: register reads answer one cycle after the read strobe
`timescale 1ns/1ns
module scm_monitor
    import scm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // measurement front end, once per power-system cycle
    input wire logic sample_valid,
    input wire logic [SCM_VW-1:0] line_side_phase_a_channel,
    input wire logic [SCM_VW-1:0] sync_side_channel,
    input wire logic [SCM_AW-1:0] angle_difference,
    input wire logic [SCM_FW-1:0] slip_frequency,
    input wire logic [SCM_VW-1:0] positive_sequence_in,
    input wire logic [SCM_VW-1:0] negative_sequence_in,
    // register port
    input wire logic [SCM_ADW-1:0] reg_addr,
    input wire logic [SCM_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [SCM_DW-1:0] reg_rdata,
    // contacts, indicators, interrupt
    output logic output_contact_first,
    output logic output_contact_second,
    output logic output_contact_third,
    output logic sync_voltage_hot,
    output logic reverse_sequence_indicator,
    output logic irq
);
    // assertion clock and reset for this module
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // band half-width from nominal and percentage
    function automatic logic [SCM_VW-1:0] scm_band_offset(
        input logic [SCM_VW-1:0] nom,
        input logic [SCM_PW-1:0] pct
    );
        logic [23:0] prod;
        logic [23:0] quot;
        prod = nom * pct;
        quot = prod / SCM_BAND_DIVISOR;
        return quot[SCM_VW-1:0];
    endfunction : scm_band_offset

    // inclusive band test shared by both sides
    function automatic logic scm_in_band(
        input logic [SCM_VW-1:0] v,
        input logic [SCM_VW-1:0] lo,
        input logic [SCM_VW-1:0] hi
    );
        return (v >= lo) && (v <= hi);
    endfunction : scm_in_band

    // settings
    logic [SCM_VW-1:0] nominal_line_voltage_setting, next_nominal;
    logic [SCM_PW-1:0] sync_voltage_diff_pickup, next_diff;
    logic [SCM_AW-1:0] sync_max_angle, next_angle;
    logic [SCM_FW-1:0] sync_max_slip, next_slip;
    logic [3:0] control, next_control;
    logic [1:0] irq_mask, next_irq_mask;
    logic [1:0] irq_stat, next_irq_stat;
    logic [SCM_DW-1:0] next_rdata;
    // sync check state
    logic sync_ok, next_sync_ok;
    logic hot, next_hot;
    logic [2:0] contacts, next_contacts;
    // derived quantities
    logic [SCM_VW-1:0] band_offset;
    logic [SCM_VW-1:0] band_low;
    logic [SCM_VW-1:0] band_high;
    logic [SCM_VW-1:0] rev_pickup;
    logic [SCM_VW-1:0] negative_sequence_voltage;
    logic phase_rotation_select;
    logic line_ok, sync_side_ok, angle_ok, slip_ok, all_ok;
    logic rev_ind, rev_ind_d;
    logic sel_write;

    assign phase_rotation_select = control[SCM_CTL_ROTATION];

    // healthy band limits
    assign band_offset = scm_band_offset(nominal_line_voltage_setting,
                                         sync_voltage_diff_pickup);
    assign band_low = (band_offset > nominal_line_voltage_setting) ? '0 :
        nominal_line_voltage_setting - band_offset;
    assign band_high = ({1'b0, nominal_line_voltage_setting} +
        {1'b0, band_offset} > {1'b0, {SCM_VW{1'b1}}}) ? {SCM_VW{1'b1}} :
        nominal_line_voltage_setting + band_offset;

    // both sides against one band, each side relative to the nominal setting
    assign line_ok = scm_in_band(line_side_phase_a_channel, band_low,
                                 band_high);
    assign sync_side_ok = scm_in_band(sync_side_channel, band_low,
                                      band_high);
    assign angle_ok = angle_difference < sync_max_angle;
    assign slip_ok = slip_frequency < sync_max_slip;
    assign all_ok = line_ok && sync_side_ok && angle_ok && slip_ok;

    // sync check evaluation, once per sample
    always_comb begin
        next_sync_ok = sync_ok;
        next_hot = hot;
        if (sample_valid) begin
            next_sync_ok = all_ok;
            next_hot = line_ok && sync_side_ok;
        end
        next_contacts = control[2:0] & {3{next_sync_ok}};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ok <= 1'b0;
            hot <= 1'b0;
            contacts <= '0;
        end else begin
            sync_ok <= next_sync_ok;
            hot <= next_hot;
            contacts <= next_contacts;
        end
    end

    assign output_contact_first = contacts[SCM_CTL_CONTACT0];
    assign output_contact_second = contacts[SCM_CTL_CONTACT1];
    assign output_contact_third = contacts[SCM_CTL_CONTACT2];
    assign sync_voltage_hot = hot;

    // rotation select swaps sequence roles
    assign negative_sequence_voltage = phase_rotation_select ?
        positive_sequence_in : negative_sequence_in;
    // fixed half-nominal pickup
    assign rev_pickup = nominal_line_voltage_setting >> SCM_REV_PICKUP_SHIFT;

    scm_reverse_detector #(
        .DELAY_CYCLES(SCM_REV_DELAY_CYCLES)
    ) u_reverse (
        .mclk(mclk),
        .rst_n(rst_n),
        .cycle_tick(sample_valid),
        .neg_seq(negative_sequence_voltage),
        .pickup(rev_pickup),
        .indicator(rev_ind)
    );
    assign reverse_sequence_indicator = rev_ind;

    // register writes, interrupt flags and read data
    assign sel_write = reg_write;
    always_comb begin
        next_nominal = nominal_line_voltage_setting;
        next_diff = sync_voltage_diff_pickup;
        next_angle = sync_max_angle;
        next_slip = sync_max_slip;
        next_control = control;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_rdata = '0;
        if (sel_write) begin
            case (reg_addr)
                SCM_REG_NOMINAL: next_nominal = reg_wdata[SCM_VW-1:0];
                SCM_REG_DIFF: next_diff = reg_wdata[SCM_PW-1:0];
                SCM_REG_ANGLE: next_angle = reg_wdata[SCM_AW-1:0];
                SCM_REG_SLIP: next_slip = reg_wdata[SCM_FW-1:0];
                SCM_REG_CONTROL: next_control = reg_wdata[3:0];
                SCM_REG_IRQ_STAT: next_irq_stat = irq_stat & ~reg_wdata[1:0];
                SCM_REG_IRQ_MASK: next_irq_mask = reg_wdata[1:0];
                default: next_control = control;
            endcase
        end
        // new events win over a clear in the same cycle
        if (!sync_ok && next_sync_ok) begin
            next_irq_stat[SCM_ST_SYNC] = 1'b1;
        end
        if (rev_ind && !rev_ind_d) begin
            next_irq_stat[SCM_ST_REVERSE] = 1'b1;
        end
        if (reg_read) begin
            case (reg_addr)
                SCM_REG_NOMINAL: next_rdata[SCM_VW-1:0] =
                    nominal_line_voltage_setting;
                SCM_REG_DIFF: next_rdata[SCM_PW-1:0] =
                    sync_voltage_diff_pickup;
                SCM_REG_ANGLE: next_rdata[SCM_AW-1:0] = sync_max_angle;
                SCM_REG_SLIP: next_rdata[SCM_FW-1:0] = sync_max_slip;
                SCM_REG_CONTROL: next_rdata[3:0] = control;
                SCM_REG_STATUS: next_rdata[2:0] = {hot, rev_ind, sync_ok};
                SCM_REG_IRQ_STAT: next_rdata[1:0] = irq_stat;
                SCM_REG_IRQ_MASK: next_rdata[1:0] = irq_mask;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nominal_line_voltage_setting <= SCM_NOMINAL_RST;
            sync_voltage_diff_pickup <= SCM_DIFF_RST;
            sync_max_angle <= SCM_ANGLE_RST;
            sync_max_slip <= SCM_SLIP_RST;
            control <= SCM_CONTROL_RST;
            irq_mask <= SCM_IRQ_MASK_RST;
            irq_stat <= '0;
            reg_rdata <= '0;
            rev_ind_d <= 1'b0;
        end else begin
            nominal_line_voltage_setting <= next_nominal;
            sync_voltage_diff_pickup <= next_diff;
            sync_max_angle <= next_angle;
            sync_max_slip <= next_slip;
            control <= next_control;
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            reg_rdata <= next_rdata;
            rev_ind_d <= rev_ind;
        end
    end

    // level interrupt from unmasked sticky flags
    assign irq = |(irq_stat & irq_mask);

    // checks on the sync check path
    a_permit_all_true: assert property (
        sample_valid && line_ok && sync_side_ok && angle_ok && slip_ok
        |=> sync_ok)
        else $error("permit missing with all conditions true");

    a_permit_drop_first: assert property (
        sample_valid && !(line_ok && sync_side_ok && angle_ok && slip_ok)
        |=> !sync_ok)
        else $error("permit held after a failed evaluation");

    a_angle_limit_block: assert property (
        sample_valid && angle_difference >= sync_max_angle |=> !sync_ok)
        else $error("permit with angle at or over limit");

    a_slip_limit_block: assert property (
        sample_valid && slip_frequency >= sync_max_slip |=> !sync_ok)
        else $error("permit with slip at or over limit");

    a_band_low_block: assert property (
        sample_valid && (line_side_phase_a_channel < band_low ||
        sync_side_channel < band_low) |=> !sync_ok && !hot)
        else $error("permit below healthy band");

    a_band_high_block: assert property (
        sample_valid && (line_side_phase_a_channel > band_high ||
        sync_side_channel > band_high) |=> !sync_ok && !hot)
        else $error("permit above healthy band");

    a_hot_both_in: assert property (
        sample_valid && line_ok && sync_side_ok |=> hot)
        else $error("voltage hot missing with both sides in band");

    a_permit_hold_idle: assert property (
        !sample_valid |=> $stable(sync_ok))
        else $error("permit moved without evaluation");

    // contacts follow the permit through their enables
    a_contact_follow: assert property (
        ##1 output_contact_first ==
        (sync_ok && $past(control[SCM_CTL_CONTACT0])))
        else $error("first contact does not follow permit");

    a_contact_third: assert property (
        ##1 output_contact_third ==
        (sync_ok && $past(control[SCM_CTL_CONTACT2])))
        else $error("third contact does not follow permit");

    a_reverse_rotation: assert property (
        phase_rotation_select |->
        negative_sequence_voltage == positive_sequence_in)
        else $error("rotation select not applied");

    // defaults put the band at 114.0 V and 126.0 V
    a_default_band: assert property (
        nominal_line_voltage_setting == SCM_NOMINAL_RST &&
        sync_voltage_diff_pickup == SCM_DIFF_RST
        |-> band_low == 16'h0474 && band_high == 16'h04ec)
        else $error("default band limits wrong");

    // sticky event flags, write-one clear and read data
    a_sync_event_flag: assert property (
        $rose(sync_ok) |-> irq_stat[SCM_ST_SYNC])
        else $error("permit rise did not set its flag");

    a_rev_event_flag: assert property (
        $rose(rev_ind) |=> irq_stat[SCM_ST_REVERSE])
        else $error("indicator rise did not set its flag");

    a_sync_flag_clear: assert property (
        reg_write && reg_addr == SCM_REG_IRQ_STAT && reg_wdata[SCM_ST_SYNC]
        |=> !irq_stat[SCM_ST_SYNC] || $rose(sync_ok))
        else $error("sync flag survived its clear");

    a_read_idle_zero: assert property (
        !reg_read |=> reg_rdata == '0)
        else $error("read data outside the answer cycle");

    // main scenarios reached
    c_permit_rise: cover property ($rose(sync_ok));
    c_permit_drop: cover property ($fell(sync_ok));
    c_irq_raised: cover property ($rose(irq));
endmodule : scm_monitor

// File: hw/scm_pkg.sv
// Purpose: shared constants for the sync check and phase sequence monitor
// Assumes: voltages in 0.1 V steps, angle in 0.1 deg, slip in mHz
// Notes: register offsets are byte addresses on the plain register port
package scm_pkg;
    localparam int SCM_VW = 16; // voltage width, 0.1 V per step
    localparam int SCM_AW = 12; // angle width, 0.1 deg per step
    localparam int SCM_FW = 16; // slip width, mHz per step
    localparam int SCM_PW = 8; // percentage width
    localparam int SCM_ADW = 8; // register address width
    localparam int SCM_DW = 32; // register data width

    // register byte offsets
    localparam logic [7:0] SCM_REG_NOMINAL = 8'h00;
    localparam logic [7:0] SCM_REG_DIFF = 8'h04;
    localparam logic [7:0] SCM_REG_ANGLE = 8'h08;
    localparam logic [7:0] SCM_REG_SLIP = 8'h0c;
    localparam logic [7:0] SCM_REG_CONTROL = 8'h10;
    localparam logic [7:0] SCM_REG_STATUS = 8'h14;
    localparam logic [7:0] SCM_REG_IRQ_STAT = 8'h18;
    localparam logic [7:0] SCM_REG_IRQ_MASK = 8'h1c;

    // reset values
    localparam logic [15:0] SCM_NOMINAL_RST = 16'h04b0; // 120.0 V
    localparam logic [7:0] SCM_DIFF_RST = 8'h0a; // 10 percent
    localparam logic [11:0] SCM_ANGLE_RST = 12'h0c8; // 20.0 deg
    localparam logic [15:0] SCM_SLIP_RST = 16'h012c; // 0.300 Hz
    localparam logic [3:0] SCM_CONTROL_RST = 4'h7; // contacts on, abc
    localparam logic [1:0] SCM_IRQ_MASK_RST = 2'h0;

    // control field positions
    localparam int SCM_CTL_CONTACT0 = 0;
    localparam int SCM_CTL_CONTACT1 = 1;
    localparam int SCM_CTL_CONTACT2 = 2;
    localparam int SCM_CTL_ROTATION = 3;
    // status and interrupt field positions
    localparam int SCM_ST_SYNC = 0;
    localparam int SCM_ST_REVERSE = 1;
    localparam int SCM_ST_HOT = 2;

    // band percent is split in halves: offset = nominal * pct / 200
    localparam logic [23:0] SCM_BAND_DIVISOR = 24'h0000c8;
    // fixed reverse sequence pickup: nominal shifted right once
    localparam int SCM_REV_PICKUP_SHIFT = 1;
    localparam int SCM_REV_DELAY_CYCLES = 30;
endpackage : scm_pkg

// File: hw/scm_reverse_detector.sv
// Purpose: reverse phase sequence qualification timer and indicator
// Assumes: cycle_tick pulses once per power-system cycle
// Notes: indicator does not latch; drops with the first low evaluation
`timescale 1ns/1ns
module scm_reverse_detector
    import scm_pkg::*;
#(
    parameter int DELAY_CYCLES = SCM_REV_DELAY_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // evaluation inputs
    input wire logic cycle_tick,
    input wire logic [SCM_VW-1:0] neg_seq,
    input wire logic [SCM_VW-1:0] pickup,
    // warning only, no trip output exists
    output logic indicator
);
    typedef enum logic [2:0] {
        SCM_RS_IDLE = 3'b001,
        SCM_RS_TIMING = 3'b010,
        SCM_RS_ALARM = 3'b100
    } scm_rs_state_t;

    // assertion clock and reset for this module
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // refuse delays that the five-bit count cannot hold
    if (DELAY_CYCLES < 1 || DELAY_CYCLES > 31) begin : g_bad_delay
        $error("scm_reverse_detector: delay out of range");
    end

    localparam logic [4:0] DELAY_LAST = 5'(DELAY_CYCLES);
    localparam logic [4:0] CNT_ONE = 5'h01;

    scm_rs_state_t state, next_state;
    logic [4:0] count, next_count;
    logic above;

    assign above = neg_seq > pickup; // strict exceed

    // next state and qualification count
    always_comb begin
        next_state = state;
        next_count = count;
        if (cycle_tick) begin
            case (state)
                SCM_RS_IDLE: begin
                    if (above) begin
                        next_count = CNT_ONE;
                        next_state = (CNT_ONE == DELAY_LAST) ?
                            SCM_RS_ALARM : SCM_RS_TIMING;
                    end
                end
                SCM_RS_TIMING: begin
                    if (!above) begin
                        next_count = '0;
                        next_state = SCM_RS_IDLE;
                    end else begin
                        next_count = count + CNT_ONE;
                        if (next_count == DELAY_LAST) begin
                            next_state = SCM_RS_ALARM;
                        end
                    end
                end
                SCM_RS_ALARM: begin
                    if (!above) begin
                        next_count = '0;
                        next_state = SCM_RS_IDLE;
                    end
                end
                default: begin
                    next_count = '0;
                    next_state = SCM_RS_IDLE;
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SCM_RS_IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // lamp only
    assign indicator = state == SCM_RS_ALARM;

    // helper: consecutive ticks seen above pickup
    logic [5:0] run_len;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_len <= '0;
        end else if (cycle_tick) begin
            run_len <= above ? ((run_len == 6'h3f) ? run_len : run_len + 6'h01)
                             : 6'h00;
        end
    end

    a_rev_delay_exact: assert property (
        indicator == (run_len >= 6'(DELAY_CYCLES)))
        else $error("reverse indicator timing mismatch");
    a_rev_drop_clear: assert property (
        cycle_tick && !above |=> !indicator && count == 5'h00)
        else $error("reverse indicator not cleared");
    a_rev_hold_between: assert property (
        !cycle_tick |=> $stable(indicator))
        else $error("reverse indicator moved without tick");
    c_rev_lights: cover property ($rose(indicator));
    c_rev_drops: cover property ($fell(indicator));
endmodule : scm_reverse_detector

// File: verif/scm_front_end.sv
// Purpose: measurement front end handing one evaluation per power cycle
// Assumes: the monitor takes the quantities at the edge with sample_valid
// Notes: between evaluations the lines carry inverted values, never stale
`timescale 1ns/1ns
module scm_front_end
    import scm_pkg::*;
(
    // clock
    input wire logic mclk,
    // measured quantities
    output logic sample_valid,
    output logic [SCM_VW-1:0] line_a,
    output logic [SCM_VW-1:0] sync_v,
    output logic [SCM_AW-1:0] angle,
    output logic [SCM_FW-1:0] slip,
    output logic [SCM_VW-1:0] pos_seq,
    output logic [SCM_VW-1:0] neg_seq
);
    // quiet front end at time zero
    initial begin
        {sample_valid, line_a, sync_v, angle, slip, pos_seq, neg_seq} = '0;
    end

    // one evaluation: valid for one cycle, then garbage on the data lines
    task automatic send(input logic [15:0] a, input logic [15:0] s,
        input logic [11:0] g, input logic [15:0] f,
        input logic [15:0] p, input logic [15:0] n);
        @(posedge mclk);
        sample_valid <= 1'b1;
        {line_a, sync_v, angle, slip, pos_seq, neg_seq} <= {a, s, g, f, p, n};
        @(posedge mclk);
        sample_valid <= 1'b0;
        {line_a, sync_v, angle, slip, pos_seq, neg_seq} <= ~{a, s, g, f, p, n};
    endtask : send
endmodule : scm_front_end

// File: verif/scm_monitor_tb_top.sv
// Purpose: self-checking bench for the sync check and sequence monitor
// Assumes: outputs settle one cycle after the evaluation edge
// Notes: nominal 120.0 V throughout, band and pickup figures follow it
`timescale 1ns/1ns
module scm_monitor_tb_top
    import scm_pkg::*;
;
    logic mclk;
    logic rst_n;
    logic sv;
    logic [15:0] va, vs, v1, v2, fs;
    logic [11:0] ang;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdv;
    logic reg_write, reg_read;
    logic c1, c2, c3, hot, rev, irq;
    int failures;
    int n_checks;

    // clock and reset
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {rst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        failures = 0;
        n_checks = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
    end

    scm_front_end scm_front_end_i (.mclk(mclk), .sample_valid(sv),
        .line_a(va), .sync_v(vs), .angle(ang), .slip(fs), .pos_seq(v1),
        .neg_seq(v2));
    scm_monitor scm_monitor_i (.mclk(mclk), .rst_n(rst_n),
        .sample_valid(sv), .line_side_phase_a_channel(va),
        .sync_side_channel(vs), .angle_difference(ang),
        .slip_frequency(fs), .positive_sequence_in(v1),
        .negative_sequence_in(v2), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .output_contact_first(c1),
        .output_contact_second(c2), .output_contact_third(c3),
        .sync_voltage_hot(hot), .reverse_sequence_indicator(rev),
        .irq(irq));

    // compare helpers
    task automatic chk_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit
    task automatic chk_word(input string what, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    // register port cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 rdv = reg_rdata;
    endtask : rd
    // one evaluation, outputs settled on return
    task automatic smp(input logic [15:0] a, input logic [15:0] s,
        input logic [11:0] g, input logic [15:0] f, input logic [15:0] n);
        scm_front_end_i.send(a, s, g, f, 16'h04b0, n);
        #1;
    endtask : smp

    // settings come out of reset at their defaults
    task automatic t_defaults;
        logic [7:0] ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40};
        logic [31:0] ex [6] = '{32'h4b0, 32'ha, 32'hc8, 32'h12c, 32'h7,
            32'h0};
        for (int i = 0; i < 6; i++) begin
            rd(ad[i]);
            chk_word("setting default", ex[i], rdv);
        end
        // read data falls back to zero after its one answer cycle
        @(posedge mclk);
        #1 chk_word("read data idle", 32'h0, reg_rdata);
    endtask : t_defaults

    // band edges on each channel, then a wider band
    task automatic t_band;
        logic [15:0] lim [4] = '{16'h0474, 16'h0473, 16'h04ec, 16'h04ed};
        logic [3:0] ex = 4'b0101;
        for (int i = 0; i < 4; i++) begin
            smp(lim[i], 16'h04b0, 12'h000, 16'h0000, 16'h0000);
            chk_bit("hot line side", ex[i], hot);
            chk_bit("contact first", ex[i], c1);
            smp(16'h04b0, lim[i], 12'h000, 16'h0000, 16'h0000);
            chk_bit("hot sync side", ex[i], hot);
        end
        wr(SCM_REG_DIFF, 32'h14);
        smp(16'h0438, 16'h04b0, 12'h000, 16'h0000, 16'h0000);
        chk_bit("hot wide band low", 1'b1, hot);
        smp(16'h0437, 16'h04b0, 12'h000, 16'h0000, 16'h0000);
        chk_bit("hot wide band out", 1'b0, hot);
        wr(SCM_REG_DIFF, 32'ha);
    endtask : t_band

    // angle and slip limits are strict
    task automatic t_limits;
        smp(16'h04b0, 16'h04b0, 12'h0c7, 16'h012b, 16'h0000);
        chk_bit("permit below limits", 1'b1, c1);
        smp(16'h04b0, 16'h04b0, 12'h0c8, 16'h0000, 16'h0000);
        chk_bit("permit at angle", 1'b0, c1);
        chk_bit("hot at angle", 1'b1, hot);
        smp(16'h04b0, 16'h04b0, 12'h000, 16'h012c, 16'h0000);
        chk_bit("permit at slip", 1'b0, c1);
    endtask : t_limits

    // contact enables pick which contacts follow the permit
    task automatic t_contacts;
        wr(SCM_REG_CONTROL, 32'h5);
        smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0000);
        chk_word("contacts", 32'h5, {29'h0, c3, c2, c1});
        wr(SCM_REG_CONTROL, 32'h7);
        smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0000);
        chk_word("contacts all", 32'h7, {29'h0, c3, c2, c1});
    endtask : t_contacts

    // reverse sequence timer, restart, release and swapped rotation
    task automatic t_reverse;
        repeat (20) smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0259);
        smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0258);
        repeat (29) smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0259);
        chk_bit("indicator after 29", 1'b0, rev);
        smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0259);
        chk_bit("indicator after 30", 1'b1, rev);
        chk_bit("contact during warning", 1'b1, c1);
        smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0258);
        chk_bit("indicator at pickup", 1'b0, rev);
        wr(SCM_REG_CONTROL, 32'hf);
        repeat (30) smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0000);
        chk_bit("indicator swapped", 1'b1, rev);
        wr(SCM_REG_CONTROL, 32'h7);
        smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0000);
        chk_bit("indicator restored", 1'b0, rev);
    endtask : t_reverse

    // sync rise raises the interrupt, mask and write-one-clear
    task automatic t_irq;
        // both events have happened earlier and stay sticky while masked
        rd(SCM_REG_IRQ_STAT);
        chk_word("irq events sticky", 32'h3, rdv);
        smp(16'h04b0, 16'h04b0, 12'h0c8, 16'h0000, 16'h0000);
        wr(SCM_REG_IRQ_STAT, 32'h3);
        wr(SCM_REG_IRQ_MASK, 32'h1);
        #1 chk_bit("irq idle", 1'b0, irq);
        smp(16'h04b0, 16'h04b0, 12'h000, 16'h0000, 16'h0000);
        chk_bit("irq on permit", 1'b1, irq);
        wr(SCM_REG_STATUS, 32'h0);
        rd(SCM_REG_STATUS);
        chk_word("status", 32'h5, rdv);
        rd(SCM_REG_IRQ_STAT);
        chk_word("irq status", 32'h1, rdv);
        wr(SCM_REG_IRQ_STAT, 32'h1);
        #1 chk_bit("irq cleared", 1'b0, irq);
        wr(SCM_REG_IRQ_MASK, 32'h0);
    endtask : t_irq

    // verdict
    task automatic final_report;
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        #100000;
        failures++;
        final_report();
    end

    // main sequence
    initial begin
        wait (rst_n === 1'b1);
        t_defaults();
        t_band();
        t_limits();
        t_contacts();
        t_reverse();
        t_irq();
        final_report();
    end
endmodule : scm_monitor_tb_top
